// ==== rtl/opa_map.svh ====
// Function
// - Shift then clip zeroes whole main odometer
// - No delay: reset holds zero while clip held
// - Main odometer reset also clips calculated time
// - Main reset leaves auxiliary odometer alone
// - Reset switch clears shown auxiliary odometer
// - Auxiliary reset leaves main and time alone
// - Delayed clip: keep counting before and after
// - Main reset never waits for hold delay
// - Delayed mode: count right after reset
// - Special position, shift, toggle swaps input
// - Factor position, reset held, plus/minus swaps input
// - Active input survives power off
// - Factor position shows factor in clock display
// - Pulse adds factor to six lowest digits
// - Factor default is 050000
// - Two factors per input, shift toggles A/B
// - Show active factor letter and value
// - Ignore adjustments from A/B select until one second after shift release
// - Adjustment changes only the active factor
// - All four factors kept in non-volatile store
// - Any six-digit decimal factor accepted
// - Clip zeroes internal and thousandths digits
// - No delay: no accumulation while clip held
// - Delayed clip fires after one second hold
`ifndef OPA_MAP_SVH
`define OPA_MAP_SVH
// ==========================================================
// Widths
`define OPA_DIGITS      11
`define OPA_ODO_W       44
`define OPA_FAC_DIG     6
`define OPA_FAC_W       24
`define OPA_TRUNC_W     24
`define OPA_CNT_W       25
`define OPA_ADDR_W      8
`define OPA_DATA_W      32
// ==========================================================
// Reset values
`define OPA_FAC_DEFAULT 24'h050000
// ==========================================================
// Register offsets
`define OPA_REG_CTRL    8'h00
`define OPA_REG_FACTOR  8'h04
`define OPA_REG_STATUS  8'h08
`define OPA_REG_MAIN_LO 8'h0C
`define OPA_REG_MAIN_HI 8'h10
`define OPA_REG_AUX_LO  8'h14
`define OPA_REG_AUX_HI  8'h18
// ==========================================================
// Field positions
`define OPA_CTRL_DELAY  0
`define OPA_ST_INPUT2   0
`define OPA_ST_FACTB    1
`define OPA_ST_LOCK     2
`define OPA_ST_CLIPHOLD 3
// ==========================================================
// Timing
`define OPA_CLK_KHZ     20000
`define OPA_HOLD_MS     1000
`define OPA_LOCK_MS     1000
`endif

// ==== rtl/opa_pkg.sv ====
`default_nettype none
package opa_pkg;
  typedef enum logic [1:0] {ROT_ODO, ROT_FACTOR, ROT_SPECIAL, ROT_OTHER} opa_rot_e;
  typedef enum logic [1:0] {CL_IDLE, CL_HOLD, CL_WAIT, CL_DONE} opa_clip_e;
  typedef struct packed {
    logic shift;
    logic clip;
    logic reset;
    logic plus;
    logic minus;
    logic odo_in;
  } opa_sw_s;
  typedef struct packed {
    logic        show_factor;
    logic [23:0] factor_val;
    logic        input2;
    logic        factor_b;
  } opa_disp_s;
  typedef struct packed {
    logic [3:0][23:0] fac;
    logic             in2;
    logic [1:0]       fb;
  } opa_nv_s;
  typedef struct packed {
    opa_sw_s     sw_prev;
    logic [1:0]  p_meta;
    logic [1:0]  p_sync;
    logic [1:0]  p_prev;
    opa_clip_e   clip_st;
    logic [24:0] hold_cnt;
    logic [24:0] lock_cnt;
    logic        ab_pend;
    logic        delay_en;
    logic [43:0] main;
    logic [43:0] aux;
    logic        calc_clip;
    opa_disp_s   disp;
    logic [31:0] rdata;
  } opa_st_s;
endpackage : opa_pkg
`default_nettype wire

// ==== rtl/opa_bcd_add.sv ====
`include "opa_map.svh"
`default_nettype none
module opa_bcd_add #(
  parameter int DIG = `OPA_DIGITS
) (
  input  wire logic [DIG*4-1:0]      odo,
  input  wire logic [`OPA_FAC_W-1:0] fac,
  output logic      [DIG*4-1:0]      sum
);
  if (DIG <= `OPA_FAC_DIG) begin : g_bad
    $error("opa_bcd_add: odometer must be wider than the factor");
  end
  logic [DIG*4-1:0] fx;
  assign fx = {{(DIG*4-`OPA_FAC_W){1'b0}}, fac};
  // Ripple decimal add; top carry is dropped so the odometer rolls over
  always_comb
  begin
    logic [4:0] t;
    logic       c;
    t = 5'h00;
    c = 1'b0;
    sum = '0;
    for (int i = 0; i < DIG; i++)
    begin
      t = {1'b0, odo[i*4+:4]} + {1'b0, fx[i*4+:4]} + {4'h0, c};
      if (t > 5'h09)
      begin
        t = t - 5'h0A;
        c = 1'b1;
      end
      else
      begin
        c = 1'b0;
      end
      sum[i*4+:4] = t[3:0];
    end
  end
endmodule : opa_bcd_add
`default_nettype wire

// ==== rtl/opa_top.sv ====
// Local design decisions: the plain strobed port and the register addresses.
`include "opa_map.svh"
`default_nettype none
module opa_top #(
  parameter int HOLD_CYC = `OPA_HOLD_MS * `OPA_CLK_KHZ,
  parameter int LOCK_CYC = `OPA_LOCK_MS * `OPA_CLK_KHZ
) (
  input  wire logic                       CLK,
  input  wire logic                       RST,
  input  wire logic                       NV_RST,
  input  wire logic                       CE,
  input  wire logic [`OPA_ADDR_W-1:0]     ADDR,
  input  wire logic [`OPA_DATA_W-1:0]     WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output logic      [`OPA_DATA_W-1:0]     RDATA,
  input  wire logic [1:0]                 PULSE_IN,
  input  wire opa_pkg::opa_sw_s           SW,
  input  wire logic [1:0]                 ROT,
  input  wire logic                       AUX_SHOWN,
  output logic      [`OPA_ODO_W-1:0]      MAIN_ODO,
  output logic      [`OPA_ODO_W-1:0]      AUX_ODO,
  output logic                            CALC_CLIP,
  output opa_pkg::opa_disp_s              DISP
);
  // ==========================================================
  // Elaboration checks
  if (HOLD_CYC < 1 || HOLD_CYC >= (1 << `OPA_CNT_W)) begin : g_bad_hold
    $error("opa_top: HOLD_CYC out of counter range");
  end
  if (LOCK_CYC < 1 || LOCK_CYC >= (1 << `OPA_CNT_W)) begin : g_bad_lock
    $error("opa_top: LOCK_CYC out of counter range");
  end

  localparam logic [`OPA_CNT_W-1:0] HOLD_END = `OPA_CNT_W'(HOLD_CYC - 1);
  localparam logic [`OPA_CNT_W-1:0] LOCK_LEN = `OPA_CNT_W'(LOCK_CYC);

  function automatic logic is_bcd(input logic [`OPA_FAC_W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < `OPA_FAC_DIG; i++)
    begin
      if (v[i*4+:4] > 4'h9)
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : is_bcd

  opa_pkg::opa_st_s  s_q;
  opa_pkg::opa_st_s  s_d;
  opa_pkg::opa_nv_s  nv_q;
  opa_pkg::opa_nv_s  nv_d;
  opa_pkg::opa_sw_s  rise;
  opa_pkg::opa_rot_e rot;
  logic [1:0]                pedge;
  logic                      act;
  logic [1:0]                fidx;
  logic [`OPA_FAC_W-1:0]     fac_sel;
  logic [`OPA_ODO_W-1:0]     sum_main;
  logic [`OPA_ODO_W-1:0]     sum_aux;
  logic                      zero_main;
  logic                      trunc;
  logic                      block;
  logic                      aux_clr;
  logic                      pm_rise;

  assign rot     = opa_pkg::opa_rot_e'(ROT);
  assign rise    = SW & ~s_q.sw_prev;
  assign pm_rise = rise.plus | rise.minus;
  assign pedge   = s_q.p_sync & ~s_q.p_prev;
  assign act     = nv_q.in2 ? pedge[1] : pedge[0];
  assign fidx    = {nv_q.in2, nv_q.fb[nv_q.in2]};
  assign fac_sel = nv_q.fac[fidx];

  // ==========================================================
  // Decimal accumulators
  opa_bcd_add #(.DIG(`OPA_DIGITS)) u_add_main (
    .odo (s_q.main),
    .fac (fac_sel),
    .sum (sum_main)
  );
  opa_bcd_add #(.DIG(`OPA_DIGITS)) u_add_aux (
    .odo (s_q.aux),
    .fac (fac_sel),
    .sum (sum_aux)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d       = s_q;
    nv_d      = nv_q;
    zero_main = 1'b0;
    trunc     = 1'b0;
    block     = 1'b0;
    aux_clr   = 1'b0;
    s_d.sw_prev   = SW;
    s_d.p_meta    = PULSE_IN;
    s_d.p_sync    = s_q.p_meta;
    s_d.p_prev    = s_q.p_sync;
    s_d.calc_clip = 1'b0;

    // Clip and reset sequencing
    case (s_q.clip_st)
      opa_pkg::CL_IDLE:
      begin
        if (rise.clip)
        begin
          if (s_q.sw_prev.shift && SW.shift)
          begin
            // Reset is never delayed
            zero_main   = 1'b1;
            s_d.clip_st = s_q.delay_en ? opa_pkg::CL_DONE : opa_pkg::CL_HOLD;
          end
          else if (!s_q.delay_en)
          begin
            trunc       = 1'b1;
            s_d.clip_st = opa_pkg::CL_HOLD;
          end
          else
          begin
            s_d.hold_cnt = '0;
            s_d.clip_st  = opa_pkg::CL_WAIT;
          end
        end
      end
      opa_pkg::CL_HOLD:
      begin
        if (!SW.clip)
        begin
          s_d.clip_st = opa_pkg::CL_IDLE;
        end
        else
        begin
          block = 1'b1;
        end
      end
      opa_pkg::CL_WAIT:
      begin
        if (!SW.clip)
        begin
          s_d.clip_st = opa_pkg::CL_IDLE;
        end
        else if (s_q.hold_cnt == HOLD_END)
        begin
          trunc       = 1'b1;
          s_d.clip_st = opa_pkg::CL_DONE;
        end
        else
        begin
          s_d.hold_cnt = s_q.hold_cnt + `OPA_CNT_W'(1);
        end
      end
      opa_pkg::CL_DONE:
      begin
        if (!SW.clip)
        begin
          s_d.clip_st = opa_pkg::CL_IDLE;
        end
      end
      default:
      begin
        s_d.clip_st = opa_pkg::CL_IDLE;
      end
    endcase

    // Main odometer; a pulse landing on the clip cycle is counted, then cut
    if (zero_main)
    begin
      s_d.main = '0;
    end
    else
    begin
      if (act && !block)
      begin
        s_d.main = sum_main;
      end
      if (trunc)
      begin
        s_d.main[`OPA_TRUNC_W-1:0] = '0;
      end
    end
    s_d.calc_clip = zero_main | trunc;

    // Auxiliary odometer ignores clip and main reset
    aux_clr = rise.reset && AUX_SHOWN && rot != opa_pkg::ROT_FACTOR;
    if (aux_clr)
    begin
      s_d.aux = '0;
    end
    else if (act)
    begin
      s_d.aux = sum_aux;
    end

    // Input and factor selection
    if (rot == opa_pkg::ROT_SPECIAL && SW.shift && rise.odo_in)
    begin
      nv_d.in2 = ~nv_q.in2;
    end
    else if (rot == opa_pkg::ROT_FACTOR && pm_rise)
    begin
      if (SW.reset)
      begin
        nv_d.in2 = ~nv_q.in2;
      end
      else if (SW.shift)
      begin
        nv_d.fb[nv_q.in2] = ~nv_q.fb[nv_q.in2];
        s_d.ab_pend       = 1'b1;
      end
    end

    // Lockout runs from shift release, so a slip of shift cannot adjust
    if (s_q.lock_cnt != '0)
    begin
      s_d.lock_cnt = s_q.lock_cnt - `OPA_CNT_W'(1);
    end
    if (s_q.ab_pend && !SW.shift)
    begin
      s_d.ab_pend  = 1'b0;
      s_d.lock_cnt = LOCK_LEN;
    end

    // Register writes
    if (WR)
    begin
      case (ADDR)
        `OPA_REG_CTRL:
        begin
          s_d.delay_en = WDATA[`OPA_CTRL_DELAY];
        end
        `OPA_REG_FACTOR:
        begin
          if (s_q.lock_cnt == '0 && !s_q.ab_pend && is_bcd(WDATA[`OPA_FAC_W-1:0]))
          begin
            nv_d.fac[fidx] = WDATA[`OPA_FAC_W-1:0];
          end
        end
        default:
        begin
        end
      endcase
    end

    // Register reads
    s_d.rdata = '0;
    if (RD)
    begin
      case (ADDR)
        `OPA_REG_CTRL:
        begin
          s_d.rdata[`OPA_CTRL_DELAY] = s_q.delay_en;
        end
        `OPA_REG_FACTOR:
        begin
          s_d.rdata[`OPA_FAC_W-1:0] = fac_sel;
        end
        `OPA_REG_STATUS:
        begin
          s_d.rdata[`OPA_ST_INPUT2]   = nv_q.in2;
          s_d.rdata[`OPA_ST_FACTB]    = nv_q.fb[nv_q.in2];
          s_d.rdata[`OPA_ST_LOCK]     = (s_q.lock_cnt != '0) | s_q.ab_pend;
          s_d.rdata[`OPA_ST_CLIPHOLD] = s_q.clip_st == opa_pkg::CL_HOLD;
        end
        `OPA_REG_MAIN_LO:
        begin
          s_d.rdata = s_q.main[31:0];
        end
        `OPA_REG_MAIN_HI:
        begin
          s_d.rdata[`OPA_ODO_W-33:0] = s_q.main[`OPA_ODO_W-1:32];
        end
        `OPA_REG_AUX_LO:
        begin
          s_d.rdata = s_q.aux[31:0];
        end
        `OPA_REG_AUX_HI:
        begin
          s_d.rdata[`OPA_ODO_W-33:0] = s_q.aux[`OPA_ODO_W-1:32];
        end
        default:
        begin
        end
      endcase
    end

    // Display indications
    s_d.disp.show_factor = rot == opa_pkg::ROT_FACTOR;
    s_d.disp.factor_val  = nv_d.fac[{nv_d.in2, nv_d.fb[nv_d.in2]}];
    s_d.disp.input2      = nv_d.in2;
    s_d.disp.factor_b    = nv_d.fb[nv_d.in2];
  end

  // ==========================================================
  // State registers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      s_q <= '0;
    end
    else if (CE)
    begin
      s_q <= s_d;
    end
  end

  // Only the factory reset touches the retained store, not power-on RST
  always_ff @(posedge CLK or posedge NV_RST)
  begin
    if (NV_RST)
    begin
      nv_q <= '{fac: {4{`OPA_FAC_DEFAULT}}, in2: 1'b0, fb: 2'b00};
    end
    else if (CE)
    begin
      nv_q <= nv_d;
    end
  end

  assign RDATA     = s_q.rdata;
  assign MAIN_ODO  = s_q.main;
  assign AUX_ODO   = s_q.aux;
  assign CALC_CLIP = s_q.calc_clip;
  assign DISP      = s_q.disp;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST || NV_RST);

  a_reset_zeroes_main: assert property (CE && zero_main |=> s_q.main == '0)
    else $error("main odometer not zero after reset");
  a_hold_keeps_zero: assert property (
    CE && s_q.clip_st == opa_pkg::CL_HOLD && s_q.main == '0 && SW.clip |=> s_q.main == '0)
    else $error("main odometer left zero while clip held");
  a_reset_clips_time: assert property (CE && zero_main |=> CALC_CLIP)
    else $error("calculated time not clipped on reset");
  a_aux_kept_reset: assert property (
    CE && zero_main && !act && !aux_clr |=> $stable(s_q.aux))
    else $error("aux odometer changed by main reset");
  a_aux_clear_zero: assert property (CE && aux_clr |=> s_q.aux == '0 && !CALC_CLIP)
    else $error("aux odometer not cleared");
  a_delay_counts_on: assert property (
    CE && s_q.delay_en && s_q.clip_st != opa_pkg::CL_HOLD && act && !trunc && !zero_main
    && fac_sel != '0 |=> s_q.main != $past(s_q.main))
    else $error("main odometer stalled in delayed mode");
  a_no_count_held: assert property (
    CE && s_q.clip_st == opa_pkg::CL_HOLD && SW.clip |=> $stable(s_q.main))
    else $error("main odometer counted while clip held");
  a_trunc_low_zero: assert property (
    CE && trunc |=> s_q.main[`OPA_TRUNC_W-1:0] == '0 && CALC_CLIP)
    else $error("clip left low digits set");
  a_lock_blocks_adj: assert property (
    CE && WR && ADDR == `OPA_REG_FACTOR && s_q.lock_cnt != '0 |=> $stable(nv_q.fac))
    else $error("factor changed during lockout");
  a_input_swap_shown: assert property (
    CE && rot == opa_pkg::ROT_SPECIAL && SW.shift && rise.odo_in
    |=> nv_q.in2 != $past(nv_q.in2) ##1 DISP.input2 == $past(nv_q.in2, 1))
    else $error("input swap not taken or not shown");
endmodule : opa_top
`default_nettype wire

// ==== verif/opa_panel.sv ====
`default_nettype none
// ==========================================================
// Transducer and front-panel model
module opa_panel (
  input  wire logic             clk,
  output var  logic [1:0]       pulse_o,
  output var  opa_pkg::opa_sw_s sw_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    pulse_o = 2'h0;
    sw_o    = '0;
  end
  // Two cycles high, then a long low so the synchroniser sees one edge
  task automatic pulse(input int i);
    @(posedge clk);
    pulse_o <= 2'h1 << i;
    repeat (2) @(posedge clk);
    pulse_o <= 2'h0;
    repeat (6) @(posedge clk);
    #1;
  endtask : pulse
  // One switch pattern per call; a reset gesture is two calls in order
  task automatic press(input logic [5:0] v);
    @(posedge clk);
    sw_o <= opa_pkg::opa_sw_s'(v);
    repeat (4) @(posedge clk);
    #1;
  endtask : press
endmodule : opa_panel
`default_nettype wire

// ==== verif/opa_top_tb.sv ====
`include "opa_map.svh"
`default_nettype none
module opa_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  localparam int         HOLD = 40;
  localparam int         LOCK = 30;
  localparam logic [5:0] SH = 6'h20, CL = 6'h10, RS = 6'h08, PL = 6'h04, MI = 6'h02, OD = 6'h01;
  logic               CLK, RST, NV_RST, CE, WR, RD;
  logic               AUX_SHOWN, rd_seen = 1'b0, CALC_CLIP;
  logic [7:0]         ADDR;
  logic [31:0]        WDATA, RDATA;
  logic [1:0]         ROT, PULSE_IN;
  opa_pkg::opa_sw_s   SW;
  opa_pkg::opa_disp_s DISP;
  logic [43:0]        MAIN_ODO, AUX_ODO, m, a;
  logic [23:0]        f;
  logic [31:0]        rq[$];
  int                 failures = 0, check_count = 0, clips = 0, n;
  always #25 CLK = ~CLK;
  opa_top #(.HOLD_CYC(HOLD), .LOCK_CYC(LOCK)) dut (.CLK(CLK), .RST(RST), .NV_RST(NV_RST), .CE(CE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PULSE_IN(PULSE_IN), .SW(SW),
    .ROT(ROT), .AUX_SHOWN(AUX_SHOWN), .MAIN_ODO(MAIN_ODO), .AUX_ODO(AUX_ODO), .CALC_CLIP(CALC_CLIP),
    .DISP(DISP));
  opa_panel u_pan (.clk(CLK), .pulse_o(PULSE_IN), .sw_o(SW));
  // ==========================================================
  // Helpers
  function automatic logic [43:0] badd(logic [43:0] o, logic [23:0] fx);
    logic [43:0] r;
    int          c;
    int          s;
    c = 0;
    for (int i = 0; i < 11; i++)
    begin
      s = o[i*4+:4] + ((i < 6) ? fx[i*4+:4] : 0) + c;
      c = (s > 9) ? 1 : 0;
      r[i*4+:4] = 4'((s > 9) ? s - 10 : s);
    end
    return r;
  endfunction : badd
  task automatic close_out();
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(string nm, logic [43:0] e, logic [43:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk
  task automatic odo();
    #1;
    chk("main", m, MAIN_ODO);
    chk("aux", a, AUX_ODO);
  endtask : odo
  task automatic wr(logic [7:0] ad, logic [31:0] d);
    @(posedge CLK);
    ADDR  <= ad;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  // The expected word is queued; the watcher pairs it with the answer
  task automatic rd(logic [7:0] ad, logic [31:0] e);
    @(posedge CLK);
    ADDR <= ad;
    RD   <= 1'b1;
    rq.push_back(e);
    @(posedge CLK);
    RD <= 1'b0;
  endtask : rd
  task automatic pl(int i, logic [23:0] fx, bit cm, bit ca);
    u_pan.pulse(i);
    if (cm) m = badd(m, fx);
    if (ca) a = badd(a, fx);
  endtask : pl
  // ==========================================================
  // Watcher: read data stand only in the cycle after the strobe
  always @(posedge CLK) rd_seen <= RD;
  always @(negedge CLK)
  begin
    if (rd_seen) chk("rdata", {12'h0, rq.pop_front()}, {12'h0, RDATA});
    if (CALC_CLIP === 1'b1) clips++;
  end
  initial
  begin
    repeat (6000) @(posedge CLK);
    failures++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    CLK       = 1'b0;
    RST       <= 1'b1;
    NV_RST    <= 1'b1;
    CE        <= 1'b1;
    WR        <= 1'b0;
    RD        <= 1'b0;
    AUX_SHOWN <= 1'b0;
    ADDR      <= 8'h00;
    WDATA     <= 32'h0;
    ROT       <= 2'h0;
    void'($urandom(71223));
    m = 44'h0;
    a = 44'h0;
    repeat (20) @(posedge CLK);
    RST    <= 1'b0;
    NV_RST <= 1'b0;
    repeat (2) @(posedge CLK);
    odo();
    rd(`OPA_REG_FACTOR, 32'h00050000);
    rd(`OPA_REG_STATUS, 32'h0);
    f = {4'h9, 20'h0};
    for (int i = 0; i < 5; i++) f[i*4+:4] = 4'($urandom % 10);
    wr(`OPA_REG_FACTOR, {8'h00, f});
    wr(8'hFC, 32'h00777777);
    rd(8'hFC, 32'h0);
    rd(`OPA_REG_FACTOR, {8'h00, f});
    n = 1 + $urandom % 4;
    repeat (n) pl(0, f, 1, 1);
    pl(1, f, 0, 0);
    odo();
    rd(`OPA_REG_MAIN_LO, m[31:0]);
    rd(`OPA_REG_MAIN_HI, {20'h0, m[43:32]});
    rd(`OPA_REG_AUX_LO, a[31:0]);
    // Enable low freezes the synchroniser, so a pulse seen only then is lost
    CE <= 1'b0;
    pl(0, f, 0, 0);
    CE <= 1'b1;
    repeat (4) @(posedge CLK);
    odo();
    // Plain clip without delay: truncate, then freeze main while held
    u_pan.press(CL);
    m[23:0] = 24'h0;
    odo();
    pl(0, f, 0, 1);
    odo();
    rd(`OPA_REG_STATUS, 32'h8);
    u_pan.press(6'h0);
    u_pan.press(SH);
    u_pan.press(SH | CL);
    m = 44'h0;
    odo();
    chk("clips", 44'h2, 44'(clips));
    pl(0, f, 0, 1);
    odo();
    u_pan.press(6'h0);
    AUX_SHOWN <= 1'b1;
    u_pan.press(RS);
    a = 44'h0;
    odo();
    chk("clips", 44'h2, 44'(clips));
    u_pan.press(6'h0);
    // Delayed mode: counting goes on before and after the clip
    wr(`OPA_REG_CTRL, 32'h1);
    u_pan.press(CL);
    pl(0, f, 1, 1);
    odo();
    chk("clips", 44'h2, 44'(clips));
    repeat (HOLD) @(posedge CLK);
    m[23:0] = 24'h0;
    odo();
    chk("clips", 44'h3, 44'(clips));
    pl(0, f, 1, 1);
    odo();
    u_pan.press(6'h0);
    u_pan.press(SH);
    u_pan.press(SH | CL);
    m = 44'h0;
    odo();
    pl(0, f, 1, 1);
    odo();
    u_pan.press(6'h0);
    // Input selection by both gestures
    ROT <= 2'h2;
    u_pan.press(SH);
    u_pan.press(SH | OD);
    chk("input2", 44'h1, 44'(DISP.input2));
    u_pan.press(6'h0);
    pl(0, f, 0, 0);
    pl(1, 24'h050000, 1, 1);
    odo();
    ROT <= 2'h1;
    u_pan.press(RS);
    u_pan.press(RS | PL);
    chk("input2", 44'h0, 44'(DISP.input2));
    odo();
    chk("show", 44'h1, 44'(DISP.show_factor));
    u_pan.press(6'h0);
    AUX_SHOWN <= 1'b0;
    // Factor A/B and the adjustment lockout
    u_pan.press(SH);
    u_pan.press(SH | MI);
    chk("factb", 44'h1, 44'(DISP.factor_b));
    chk("facval", 44'h050000, 44'(DISP.factor_val));
    u_pan.press(6'h0);
    wr(`OPA_REG_FACTOR, 32'h00123456);
    rd(`OPA_REG_FACTOR, 32'h00050000);
    repeat (LOCK + 5) @(posedge CLK);
    wr(`OPA_REG_FACTOR, 32'h0);
    rd(`OPA_REG_FACTOR, 32'h0);
    u_pan.press(SH);
    u_pan.press(SH | PL);
    chk("factb", 44'h0, 44'(DISP.factor_b));
    chk("facval", {20'h0, f}, 44'(DISP.factor_val));
    u_pan.press(6'h0);
    // Power cycle keeps the selection and the factors
    ROT <= 2'h2;
    u_pan.press(SH);
    u_pan.press(SH | OD);
    u_pan.press(6'h0);
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    repeat (3) @(posedge CLK);
    m = 44'h0;
    a = 44'h0;
    odo();
    chk("input2", 44'h1, 44'(DISP.input2));
    u_pan.press(SH);
    u_pan.press(SH | OD);
    u_pan.press(6'h0);
    ROT <= 2'h1;
    repeat (3) @(posedge CLK);
    #1;
    chk("facval", {20'h0, f}, 44'(DISP.factor_val));
    // Factory reset brings the shown factor, A/B and input back to their defaults
    NV_RST <= 1'b1;
    repeat (2) @(posedge CLK);
    NV_RST <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    chk("facval", 44'h050000, 44'(DISP.factor_val));
    chk("factb", 44'h0, 44'(DISP.factor_b));
    chk("input2", 44'h0, 44'(DISP.input2));
    close_out();
  end
endmodule : opa_top_tb
`default_nettype wire
